// File: design/vectored_interrupt_control.sv
// Vectored interrupt controller: three sources, APB registers, core hand-off
//
// Chosen here: the APB slave port.

module vectored_interrupt_control #(
	parameter int VEC_WIDTH = vic_pkg::VEC_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [vic_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Request sources
	input wire logic ext_pin,
	input wire logic timer_match,
	input wire logic serial_done,
	// Core sequencer
	input wire logic instr_boundary,
	input wire logic enable_instruction,
	input wire logic disable_instruction,
	input wire logic [vic_pkg::FLAGS_W-1:0] core_flags,
	output logic vector_take,
	output logic [VEC_WIDTH-1:0] vector_addr,
	output logic [vic_pkg::FLAGS_W-1:0] saved_flags,
	output logic wake_request
);
	if (VEC_WIDTH != vic_pkg::VEC_W) begin : g_bad_width
		$error("VEC_WIDTH must equal the vector address width");
	end

	typedef struct packed {
		logic global_accept_mask;
		logic [vic_pkg::NUM_SRC-1:0] source_request_flag;
		logic [vic_pkg::NUM_SRC-1:0] source_enable_flag;
		logic [1:0] edge_select;
		logic [vic_pkg::FLAGS_W-1:0] saved;
		logic take;
		logic [vic_pkg::VEC_W-1:0] vec;
		logic wake;
		logic ready;
		logic err;
		logic [31:0] rdata;
	} ctl_state_t;

	ctl_state_t cur;
	ctl_state_t next_cur;
	logic pin_level;
	logic pin_event;
	logic [vic_pkg::NUM_SRC-1:0] qualified;
	logic [vic_pkg::NUM_SRC-1:0] grant;
	logic [vic_pkg::VEC_W-1:0] win_vector;
	logic [vic_pkg::NUM_SRC-1:0] events;
	logic accept;
	logic setup;
	logic wr_now;
	logic [vic_pkg::NUM_REGS-1:0] rsel;
	logic [vic_pkg::NUM_REGS-1:0] wsel;

	function automatic logic [vic_pkg::NUM_REGS-1:0] reg_sel(
		input logic [vic_pkg::ADDR_W-1:0] a
	);
		logic [vic_pkg::IDX_W-1:0] idx;
		logic [vic_pkg::NUM_REGS-1:0] s;
		idx = a[vic_pkg::IDX_W+1:2];
		s = '0;
		if (a[1:0] == 2'h0 && a[vic_pkg::ADDR_W-1:vic_pkg::IDX_W+2] == '0) begin
			s[vic_pkg::SEL_PIN_LEVEL] = (idx == vic_pkg::IDX_PIN_LEVEL);
			s[vic_pkg::SEL_EDGE] = (idx == vic_pkg::IDX_EDGE_SELECT);
			s[vic_pkg::SEL_ENABLE] = (idx == vic_pkg::IDX_ENABLE);
			s[vic_pkg::SEL_SERIAL] = (idx == vic_pkg::IDX_SERIAL_REQ);
			s[vic_pkg::SEL_TIMER] = (idx == vic_pkg::IDX_TIMER_REQ);
			s[vic_pkg::SEL_PIN_REQ] = (idx == vic_pkg::IDX_PIN_REQ);
			s[vic_pkg::SEL_STATUS] = (idx == vic_pkg::IDX_CORE_STATUS);
		end
		return s;
	endfunction : reg_sel

	pin_edge_detect u_pin (
		.clk(clk),
		.reset(reset),
		.pin(ext_pin),
		.edge_select(cur.edge_select),
		.level(pin_level),
		.event_pulse(pin_event)
	);

	// Qualification ignores the global mask so wake-up still works under disable
	assign qualified = cur.source_request_flag & cur.source_enable_flag;

	source_priority u_prio (
		.request(qualified),
		.grant(grant),
		.vector(win_vector)
	);

	assign events = {serial_done, timer_match, pin_event};
	assign accept = instr_boundary && cur.global_accept_mask && (|qualified);
	assign setup = psel && !penable;
	assign wr_now = psel && penable && cur.ready && pwrite;
	assign rsel = reg_sel(paddr);
	assign wsel = wr_now ? reg_sel(paddr) : '0;

	always_comb begin
		next_cur = cur;
		// Mask: acceptance clears, enable sets, disable wins last
		if (accept) begin
			next_cur.global_accept_mask = 1'b0;
		end
		if (enable_instruction) begin
			next_cur.global_accept_mask = 1'b1;
		end
		if (disable_instruction) begin
			next_cur.global_accept_mask = 1'b0;
		end
		// Request flags: events win over any clear
		for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
			if (accept && grant[i]) begin
				next_cur.source_request_flag[i] = 1'b0;
			end
			// Flag registers sit in reverse source order
			if (wsel[vic_pkg::SEL_PIN_REQ - i]) begin
				next_cur.source_request_flag[i] = pwdata[0];
			end
			if (events[i]) begin
				next_cur.source_request_flag[i] = 1'b1;
			end
		end
		if (wsel[vic_pkg::SEL_ENABLE]) begin
			next_cur.source_enable_flag = pwdata[vic_pkg::NUM_SRC-1:0];
		end
		if (wsel[vic_pkg::SEL_EDGE]) begin
			next_cur.edge_select = pwdata[1:0];
		end
		// Only the flags go on the stack, never the data buffer
		next_cur.take = accept;
		if (accept) begin
			next_cur.saved = core_flags;
			next_cur.vec = win_vector;
		end
		next_cur.wake = |qualified;
		// APB: answer in the first access cycle
		next_cur.ready = setup;
		// Error rides with ready, so pslverr stays a bare flop
		next_cur.err = setup && !(|rsel);
		if (setup) begin
			next_cur.rdata = '0;
			unique case (1'b1)
				rsel[vic_pkg::SEL_PIN_LEVEL]: next_cur.rdata[0] = pin_level;
				rsel[vic_pkg::SEL_EDGE]: next_cur.rdata[1:0] = cur.edge_select;
				rsel[vic_pkg::SEL_ENABLE]: begin
					next_cur.rdata[vic_pkg::NUM_SRC-1:0] = cur.source_enable_flag;
				end
				rsel[vic_pkg::SEL_SERIAL]: begin
					next_cur.rdata[0] = cur.source_request_flag[vic_pkg::SRC_SERIAL];
				end
				rsel[vic_pkg::SEL_TIMER]: begin
					next_cur.rdata[0] = cur.source_request_flag[vic_pkg::SRC_TIMER];
				end
				rsel[vic_pkg::SEL_PIN_REQ]: begin
					next_cur.rdata[0] = cur.source_request_flag[vic_pkg::SRC_PIN];
				end
				rsel[vic_pkg::SEL_STATUS]: begin
					next_cur.rdata[vic_pkg::STATUS_MASK_BIT] = cur.global_accept_mask;
					next_cur.rdata[vic_pkg::STATUS_FLAGS_LSB +: vic_pkg::FLAGS_W] = cur.saved;
				end
				default: next_cur.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cur <= '0;
			cur.edge_select <= vic_pkg::EDGE_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign prdata = cur.rdata;
	assign pready = cur.ready;
	assign pslverr = cur.err;
	assign vector_take = cur.take;
	assign vector_addr = cur.vec;
	assign saved_flags = cur.saved;
	assign wake_request = cur.wake;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_take_pin;
		instr_boundary && cur.global_accept_mask &&
			cur.source_request_flag[0] && cur.source_enable_flag[0];
	endsequence
	sequence s_take_timer_only;
		instr_boundary && cur.global_accept_mask && !qualified[0] && qualified[1];
	endsequence
	sequence s_vector(logic [vic_pkg::VEC_W-1:0] v);
		vector_take && vector_addr == v;
	endsequence
	sequence s_take_serial_only;
		instr_boundary && cur.global_accept_mask && !qualified[vic_pkg::SRC_PIN] &&
			!qualified[vic_pkg::SRC_TIMER] && qualified[vic_pkg::SRC_SERIAL];
	endsequence

	property p_pin_vector;
		s_take_pin |=> s_vector(vic_pkg::VEC_PIN);
	endproperty
	a_pin_vector: assert property (p_pin_vector) else $error("pin vector wrong");

	property p_timer_vector;
		s_take_timer_only |=> s_vector(vic_pkg::VEC_TIMER);
	endproperty
	a_timer_vector: assert property (p_timer_vector) else $error("timer vector wrong");

	property p_needs_mask;
		vector_take |-> $past(cur.global_accept_mask) && $past(|qualified);
	endproperty
	a_needs_mask: assert property (p_needs_mask) else $error("accept without enable");

	property p_stack;
		instr_boundary && cur.global_accept_mask && |qualified
			|=> saved_flags == $past(core_flags);
	endproperty
	a_stack: assert property (p_stack) else $error("flags not saved");

	property p_pin_clear;
		s_take_pin and (!pin_event && !wr_now) |=> !cur.source_request_flag[0];
	endproperty
	a_pin_clear: assert property (p_pin_clear) else $error("pin flag kept");

	property p_serial_set;
		serial_done |=> cur.source_request_flag[vic_pkg::SRC_SERIAL];
	endproperty
	a_serial_set: assert property (p_serial_set) else $error("serial flag not set");

	property p_hold;
		cur.source_request_flag[1] && !cur.source_enable_flag[1] && !wr_now
			|=> cur.source_request_flag[1];
	endproperty
	a_hold: assert property (p_hold) else $error("blocked request lost");

	property p_disable;
		disable_instruction |=> !cur.global_accept_mask ##1 !vector_take;
	endproperty
	a_disable: assert property (p_disable) else $error("disable ignored");

	property p_wake;
		(|qualified) [*2] |-> wake_request;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	property p_apb;
		setup |=> pready ##1 !pready;
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer timing");

	property p_serial_vector;
		s_take_serial_only |=> s_vector(vic_pkg::VEC_SERIAL);
	endproperty
	a_serial_vector: assert property (p_serial_vector) else $error("serial vector wrong");

	property p_serial_clear;
		s_take_serial_only and (!serial_done && !wr_now)
			|=> !cur.source_request_flag[vic_pkg::SRC_SERIAL];
	endproperty
	a_serial_clear: assert property (p_serial_clear) else $error("serial flag kept");

	property p_timer_set;
		timer_match |=> cur.source_request_flag[vic_pkg::SRC_TIMER];
	endproperty
	a_timer_set: assert property (p_timer_set) else $error("timer flag not set");

	property p_pin_set;
		pin_event |=> cur.source_request_flag[vic_pkg::SRC_PIN];
	endproperty
	a_pin_set: assert property (p_pin_set) else $error("pin flag not set");

	property p_no_take_masked;
		!cur.global_accept_mask |=> !vector_take;
	endproperty
	a_no_take_masked: assert property (p_no_take_masked) else $error("masked take");

	property p_enable;
		enable_instruction && !disable_instruction |=> cur.global_accept_mask;
	endproperty
	a_enable: assert property (p_enable) else $error("enable ignored");

	property p_wake_off;
		(!(|qualified)) [*2] |-> !wake_request;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake without request");

	// Stack and vector move only with a take pulse
	property p_saved_hold;
		!vector_take |-> $stable(saved_flags);
	endproperty
	a_saved_hold: assert property (p_saved_hold) else $error("saved flags moved");

	property p_vec_hold;
		!vector_take |-> $stable(vector_addr);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved");

	property p_apb_err;
		setup && !(|rsel) |=> pslverr;
	endproperty
	a_apb_err: assert property (p_apb_err) else $error("no error answer");

	property p_err_ready;
		!pready |-> !pslverr;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");

	property p_grant_onehot;
		$onehot0(grant);
	endproperty
	a_grant_onehot: assert property (p_grant_onehot) else $error("several grants");

	property p_edge_write;
		wsel[vic_pkg::SEL_EDGE] |=> cur.edge_select == $past(pwdata[1:0]);
	endproperty
	a_edge_write: assert property (p_edge_write) else $error("edge select not written");
endmodule : vectored_interrupt_control

// File: design/vic_pkg.sv
// Constants shared by the vectored interrupt controller files
package vic_pkg;
	// APB address width and register word indices (byte address = index * 4)
	localparam int ADDR_W = 12;
	localparam int IDX_W = 8;
	localparam logic [IDX_W-1:0] IDX_PIN_LEVEL = 8'h0F;
	localparam logic [IDX_W-1:0] IDX_EDGE_SELECT = 8'h1F;
	localparam logic [IDX_W-1:0] IDX_ENABLE = 8'h2F;
	localparam logic [IDX_W-1:0] IDX_SERIAL_REQ = 8'h3D;
	localparam logic [IDX_W-1:0] IDX_TIMER_REQ = 8'h3E;
	localparam logic [IDX_W-1:0] IDX_PIN_REQ = 8'h3F;
	localparam logic [IDX_W-1:0] IDX_CORE_STATUS = 8'h40;
	localparam int NUM_REGS = 7;
	// Register select positions
	localparam int SEL_PIN_LEVEL = 0;
	localparam int SEL_EDGE = 1;
	localparam int SEL_ENABLE = 2;
	localparam int SEL_SERIAL = 3;
	localparam int SEL_TIMER = 4;
	localparam int SEL_PIN_REQ = 5;
	localparam int SEL_STATUS = 6;
	// Sources, in priority order: bit 0 highest
	localparam int NUM_SRC = 3;
	localparam int SRC_PIN = 0;
	localparam int SRC_TIMER = 1;
	localparam int SRC_SERIAL = 2;
	// Vector addresses
	localparam int VEC_W = 12;
	localparam logic [VEC_W-1:0] VEC_PIN = 12'h003;
	localparam logic [VEC_W-1:0] VEC_TIMER = 12'h002;
	localparam logic [VEC_W-1:0] VEC_SERIAL = 12'h001;
	localparam logic [VEC_W-1:0] VEC_NONE = 12'h000;
	// Edge select encodings
	localparam logic [1:0] EDGE_RISING = 2'h0;
	localparam logic [1:0] EDGE_FALLING = 2'h1;
	localparam int EDGE_BOTH_BIT = 1;
	localparam logic [1:0] EDGE_RESET = 2'h0;
	// Saved core flags: decimal, compare, carry, zero, index enable
	localparam int FLAGS_W = 5;
	localparam int STATUS_MASK_BIT = 0;
	localparam int STATUS_FLAGS_LSB = 1;
endpackage : vic_pkg

// File: design/pin_edge_detect.sv
// External pin synchroniser with selectable edge detection
module pin_edge_detect (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pin and edge mode
	input wire logic pin,
	input wire logic [1:0] edge_select,
	// Results
	output logic level,
	output logic event_pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
	} edge_state_t;

	edge_state_t cur;
	edge_state_t next_cur;
	logic rise;
	logic fall;

	always_comb begin
		next_cur = cur;
		next_cur.s1 = pin;
		next_cur.s2 = cur.s1;
		next_cur.prev = cur.s2;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign rise = cur.s2 && !cur.prev;
	assign fall = !cur.s2 && cur.prev;
	assign level = cur.s2;
	// 1x selects both edges
	assign event_pulse = edge_select[vic_pkg::EDGE_BOTH_BIT] ? (rise || fall) :
		(edge_select == vic_pkg::EDGE_FALLING) ? fall : rise;
endmodule : pin_edge_detect

// File: design/source_priority.sv
// Fixed priority pick among qualified requests
module source_priority (
	// Qualified requests
	input wire logic [vic_pkg::NUM_SRC-1:0] request,
	// Winner
	output logic [vic_pkg::NUM_SRC-1:0] grant,
	output logic [vic_pkg::VEC_W-1:0] vector
);
	function automatic logic [vic_pkg::NUM_SRC-1:0] pick(input logic [vic_pkg::NUM_SRC-1:0] r);
		logic [vic_pkg::NUM_SRC-1:0] g;
		g = '0;
		for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (r[i]) begin
				g = '0;
				g[i] = 1'b1;
			end
		end
		return g;
	endfunction : pick

	always_comb begin
		grant = pick(request);
		vector = vic_pkg::VEC_NONE;
		if (grant[vic_pkg::SRC_PIN]) begin
			vector = vic_pkg::VEC_PIN;
		end else if (grant[vic_pkg::SRC_TIMER]) begin
			vector = vic_pkg::VEC_TIMER;
		end else if (grant[vic_pkg::SRC_SERIAL]) begin
			vector = vic_pkg::VEC_SERIAL;
		end
	end
endmodule : source_priority

// File: tb/core_model.sv
// Core sequencer model: boundary strobe and vector hand-off capture
module core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Hand-off from controller
	input wire logic vector_take,
	input wire logic [vic_pkg::VEC_W-1:0] vector_addr,
	// Core side
	output logic instr_boundary,
	output int takes,
	output logic [vic_pkg::VEC_W-1:0] last_vec
);
	timeunit 1ns;
	timeprecision 1ps;
	// Every cycle is a boundary, the tightest timing for acceptance
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			instr_boundary <= 1'b0;
			takes <= 0;
			last_vec <= 12'h000;
		end else begin
			instr_boundary <= 1'b1;
			if (vector_take) begin
				takes <= takes + 1;
				last_vec <= vector_addr;
			end
		end
	end
endmodule : core_model

// File: tb/testbench.sv
// Self-checking bench for the vectored interrupt controller
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr, vector_addr, last_vec;
	logic [31:0] pwdata, prdata, rd;
	logic ext_pin, instr_boundary, vector_take, wake_request;
	logic [3:0] ev;
	logic [4:0] core_flags, saved_flags;
	int takes, err_total, compares;

	vectored_interrupt_control u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_pin(ext_pin), .timer_match(ev[0]), .serial_done(ev[1]),
		.instr_boundary(instr_boundary), .enable_instruction(ev[2]),
		.disable_instruction(ev[3]), .core_flags(core_flags), .vector_take(vector_take),
		.vector_addr(vector_addr), .saved_flags(saved_flags), .wake_request(wake_request));
	core_model u_core (.clk(clk), .reset(reset), .vector_take(vector_take),
		.vector_addr(vector_addr), .instr_boundary(instr_boundary), .takes(takes),
		.last_vec(last_vec));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task print_verdict;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Read just after the edge: these are the values that edge sampled
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Bits: timer match, serial done, enable, disable
	task pulse(input logic [3:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
	endtask : pulse

	task wait_take(input int n);
		for (int i = 0; i < 20 && takes < n; i++) @(negedge clk);
		chk(takes, n);
	endtask : wait_take

	task t_reset;
		static logic [11:0] regs [6] = '{12'h07C, 12'h0BC, 12'h0F4, 12'h0F8, 12'h0FC, 12'h100};
		foreach (regs[i]) begin
			apb(1'b0, regs[i], 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 12'h200, 32'h0);
		chk(rerr, 1'b1);
		$display("t_reset done");
	endtask : t_reset

	task t_priority;
		core_flags <= 5'h15;
		apb(1'b1, 12'h0BC, 32'h7);
		pulse(4'h3);
		apb(1'b1, 12'h0FC, 32'h1);
		pulse(4'h4);
		wait_take(1);
		chk(last_vec, 12'h003);
		chk(saved_flags, 5'h15);
		apb(1'b0, 12'h0FC, 32'h0);
		chk(rd, 32'h0);
		core_flags <= 5'h0A;
		pulse(4'h4);
		wait_take(2);
		chk(last_vec, 12'h002);
		chk(saved_flags, 5'h0A);
		pulse(4'h4);
		wait_take(3);
		chk(last_vec, 12'h001);
		pulse(4'h4);
		apb(1'b0, 12'h100, 32'h0);
		chk(rd[0], 1'b1);
		pulse(4'h8);
		apb(1'b0, 12'h100, 32'h0);
		chk(rd[0], 1'b0);
		$display("t_priority done");
	endtask : t_priority

	task t_mask;
		apb(1'b1, 12'h0BC, 32'h2);
		pulse(4'h2);
		repeat (4) @(negedge clk);
		chk(wake_request, 1'b0);
		pulse(4'h1);
		repeat (4) @(negedge clk);
		chk(wake_request, 1'b1);
		chk(takes, 3);
		pulse(4'h4);
		wait_take(4);
		chk(last_vec, 12'h002);
		apb(1'b0, 12'h0F4, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h0F4, 32'h0);
		apb(1'b0, 12'h0F4, 32'h0);
		chk(rd, 32'h0);
		$display("t_mask done");
	endtask : t_mask

	task t_pin;
		apb(1'b1, 12'h07C, 32'h1);
		ext_pin <= 1'b1;
		repeat (6) @(posedge clk);
		apb(1'b0, 12'h03C, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 12'h0FC, 32'h0);
		chk(rd, 32'h0);
		ext_pin <= 1'b0;
		repeat (6) @(posedge clk);
		apb(1'b0, 12'h0FC, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h0FC, 32'h0);
		apb(1'b1, 12'h07C, 32'h2);
		ext_pin <= 1'b1;
		repeat (6) @(posedge clk);
		apb(1'b0, 12'h0FC, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h03C, 32'h0);
		apb(1'b0, 12'h03C, 32'h0);
		chk(rd, 32'h1);
		$display("t_pin done");
	endtask : t_pin

	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_pin = 1'b0;
		ev = 4'h0;
		core_flags = 5'h00;
		err_total = 0;
		compares = 0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_priority();
		t_mask();
		t_pin();
		print_verdict();
	end

	// Run needs under 200 cycles; the 5000-cycle limit leaves ample margin
	initial begin
		#50000;
		err_total++;
		print_verdict();
	end
endmodule : testbench
